// [hw/cesr_regs.sv]
`timescale 1ns/10ps
module cesr_regs import cesr_pkg::*; #(
    parameter int NUM_BUFS = 64
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire cesr_host_buf_t host_buf,
    input wire logic [NUM_BUFS-1:0] engine_locked,
    input wire cesr_events_t events,
    input wire cesr_len_cfg_t len_cfg,
    input wire logic [NUM_BUFS-1:0] buffer_irq_flag,
    input wire logic [NUM_BUFS-1:0] buffer_irq_enable,
    input wire logic [NUM_BUFS-1:0] buffer_is_tx,
    input wire cesr_slot_status_t slot_status_a,
    input wire cesr_slot_status_t slot_status_b,
    input wire cesr_proto_status_t proto_status,
    output logic buf_wr_accept,
    output logic lock_grant,
    output logic mgmt_vec_update,
    output logic [3:0] mgmt_vec_bytes,
    output logic iface_err_irq
);

    // eight-bit index and vector fields cap the buffer count
    localparam int IDXW = (NUM_BUFS > 1) ? $clog2(NUM_BUFS) : 1;

    if (NUM_BUFS < 1 || NUM_BUFS > 256) begin : g_bad_bufs
        $error("NUM_BUFS must be 1..256");
    end

    // ====================================================================
    // state
    typedef struct packed {
        logic [CESR_NUM_FLAGS-1:0] flags;
        logic iface_err_irq_enable;
        logic [7:0] last_utilized_buffer;
        logic [15:0] cnt_a;
        logic [15:0] cnt_b;
        logic [7:0] tx_irq_vector;
        logic [7:0] rx_irq_vector;
        cesr_proto_status_t psr;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic buf_wr_accept;
        logic lock_grant;
        logic mgmt_vec_update;
        logic [3:0] mgmt_vec_bytes;
        logic irq;
    } cesr_state_t;

    cesr_state_t s_q;
    cesr_state_t s_d;

    // ====================================================================
    // priority search for vectors, one bit per buffer
    logic [NUM_BUFS-1:0] tx_pend;
    logic [NUM_BUFS-1:0] rx_pend;
    logic [NUM_BUFS-1:0] tx_first;
    logic [NUM_BUFS-1:0] rx_first;
    logic [NUM_BUFS:0] tx_seen;
    logic [NUM_BUFS:0] rx_seen;
    logic [7:0] tx_idx [NUM_BUFS+1];
    logic [7:0] rx_idx [NUM_BUFS+1];

    assign tx_seen[0] = 1'b0;
    assign rx_seen[0] = 1'b0;
    assign tx_idx[0] = 8'h00;
    assign rx_idx[0] = 8'h00;

    genvar gi;
    generate
        for (gi = 0; gi < NUM_BUFS; gi++) begin : g_vec
            assign tx_pend[gi] = buffer_irq_flag[gi] & buffer_irq_enable[gi] & buffer_is_tx[gi];
            assign rx_pend[gi] = buffer_irq_flag[gi] & buffer_irq_enable[gi] & ~buffer_is_tx[gi];
            // lower index wins
            assign tx_first[gi] = tx_pend[gi] & ~tx_seen[gi];
            assign rx_first[gi] = rx_pend[gi] & ~rx_seen[gi];
            assign tx_seen[gi+1] = tx_seen[gi] | tx_pend[gi];
            assign rx_seen[gi+1] = rx_seen[gi] | rx_pend[gi];
            assign tx_idx[gi+1] = tx_first[gi] ? 8'(gi) : tx_idx[gi];
            assign rx_idx[gi+1] = rx_first[gi] ? 8'(gi) : rx_idx[gi];
        end
    endgenerate

    // ====================================================================
    // next state
    logic wr_acc;
    logic rd_acc;
    logic wr_fin;
    logic [CESR_NUM_FLAGS-1:0] set_ev;
    logic [CESR_NUM_FLAGS-1:0] clr_ev;
    logic err_a;
    logic err_b;
    logic [7:0] idx_lim;

    always_comb begin
        s_d = s_q;
        wr_acc = psel & penable & pwrite & ~s_q.pready;
        rd_acc = psel & penable & ~pwrite & ~s_q.pready;
        wr_fin = psel & penable & pwrite & s_q.pready;
        idx_lim = 8'(NUM_BUFS - 1);
        set_ev = '0;
        clr_ev = '0;

        set_ev[CESR_BIT_BUF_UTIL] = host_buf.wr & (host_buf.index > s_q.last_utilized_buffer);
        set_ev[CESR_BIT_LOCK] = host_buf.lock_req & (host_buf.index <= idx_lim)
            & engine_locked[host_buf.index[IDXW-1:0]];
        set_ev[CESR_BIT_SYSBUS_FAIL] = events.sysbus_timeout;
        set_ev[CESR_BIT_FRAME_IDENT] = events.frame_ident_mismatch;
        set_ev[CESR_BIT_DYN_LEN] = events.dyn_tx_hdr & (events.dyn_tx_len > len_cfg.max_dyn_len);
        set_ev[CESR_BIT_STATIC_LEN] = events.static_tx_hdr & (events.static_tx_len != len_cfg.static_len);
        set_ev[CESR_BIT_MGMT_LEN] = events.static_rx_hdr
            & (events.static_rx_len < {3'h0, len_cfg.mgmt_vec_len});
        set_ev[CESR_BIT_MGMT_FRAME] = events.static_rx_frame & events.preamble_indicator
            & events.null_frame_indicator;
        set_ev[CESR_BIT_ILLEGAL_ADDR] = events.illegal_addr;

        s_d.buf_wr_accept = host_buf.wr & ~set_ev[CESR_BIT_BUF_UTIL];
        s_d.lock_grant = host_buf.lock_req & ~set_ev[CESR_BIT_LOCK];

        // vector update: short length updates only the received part
        s_d.mgmt_vec_update = events.static_rx_frame & events.preamble_indicator
            & ~events.null_frame_indicator;
        if (events.static_rx_len < {3'h0, len_cfg.mgmt_vec_len}) begin
            s_d.mgmt_vec_bytes = events.static_rx_len[3:0];
        end else begin
            s_d.mgmt_vec_bytes = len_cfg.mgmt_vec_len;
        end

        // slot status strobe arrives at slot end; count lands next cycle
        err_a = slot_status_a.syntax_err | slot_status_a.content_err
            | slot_status_a.boundary_viol | slot_status_a.tx_conflict;
        err_b = slot_status_b.syntax_err | slot_status_b.content_err
            | slot_status_b.boundary_viol | slot_status_b.tx_conflict;
        if (slot_status_a.valid && err_a) begin
            s_d.cnt_a = s_q.cnt_a + 16'h0001;
        end
        if (slot_status_b.valid && err_b) begin
            s_d.cnt_b = s_q.cnt_b + 16'h0001;
        end

        s_d.tx_irq_vector = tx_idx[NUM_BUFS];
        s_d.rx_irq_vector = rx_idx[NUM_BUFS];
        s_d.psr = proto_status;

        // ================================================================
        // apb slave: one wait state, answer registered
        s_d.pready = wr_acc | rd_acc;
        s_d.pslverr = 1'b0;
        s_d.prdata = 32'h0000_0000;
        if (wr_acc) begin
            case (paddr)
                CESR_OFS_ERR_FLAGS, CESR_OFS_CTRL, CESR_OFS_IRQ_VEC, CESR_OFS_CHA_CNT, CESR_OFS_CHB_CNT,
                CESR_OFS_PSR0: begin
                    s_d.pslverr = 1'b0;
                end
                default: begin
                    s_d.pslverr = 1'b1;
                end
            endcase
        end
        // write lands only at the edge where the master sees pready
        if (wr_fin) begin
            case (paddr)
                CESR_OFS_ERR_FLAGS: begin
                    if (pstrb[0]) begin
                        clr_ev[7:0] = pwdata[7:0];
                    end
                    if (pstrb[1]) begin
                        clr_ev[8] = pwdata[8];
                    end
                end
                CESR_OFS_CTRL: begin
                    if (pstrb[0]) begin
                        s_d.iface_err_irq_enable = pwdata[CESR_POS_IRQ_EN];
                    end
                    if (pstrb[1]) begin
                        s_d.last_utilized_buffer = pwdata[CESR_POS_LAST_UTIL +: 8];
                    end
                end
                default: begin
                    clr_ev = '0;
                end
            endcase
        end
        if (rd_acc) begin
            case (paddr)
                CESR_OFS_ERR_FLAGS: s_d.prdata = {23'h0, s_q.flags};
                CESR_OFS_IRQ_VEC: s_d.prdata = {16'h0, s_q.rx_irq_vector, s_q.tx_irq_vector};
                CESR_OFS_CHA_CNT: s_d.prdata = {16'h0, s_q.cnt_a};
                CESR_OFS_CHB_CNT: s_d.prdata = {16'h0, s_q.cnt_b};
                CESR_OFS_PSR0: s_d.prdata = {16'h0, s_q.psr.error_mode_field, s_q.psr.slot_mode_field, 1'b0,
                    s_q.psr.protocol_state_field, s_q.psr.startup_field, 1'b0, s_q.psr.wakeup_field};
                CESR_OFS_CTRL: s_d.prdata = {16'h0, s_q.last_utilized_buffer, 7'h0, s_q.iface_err_irq_enable};
                default: s_d.pslverr = 1'b1;
            endcase
        end

        // set wins over a clear in the same cycle
        s_d.flags = (s_q.flags & ~clr_ev) | set_ev;
        s_d.irq = s_q.iface_err_irq_enable & (|s_q.flags);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '0;
            s_q.last_utilized_buffer <= CESR_RST_LAST_UTIL;
            s_q.cnt_a <= CESR_RST_COUNT;
            s_q.cnt_b <= CESR_RST_COUNT;
        end else begin
            s_q <= s_d;
        end
    end

    // ====================================================================
    // outputs
    assign prdata = s_q.prdata;
    assign pready = s_q.pready;
    assign pslverr = s_q.pslverr;
    assign buf_wr_accept = s_q.buf_wr_accept;
    assign lock_grant = s_q.lock_grant;
    assign mgmt_vec_update = s_q.mgmt_vec_update;
    assign mgmt_vec_bytes = s_q.mgmt_vec_bytes;
    assign iface_err_irq = s_q.irq;

endmodule

// [hw/cesr_pkg.sv]
package cesr_pkg;

    // ====================================================================
    // register offsets (byte addresses on the apb bus)
    localparam logic [7:0] CESR_OFS_ERR_FLAGS = 8'h00;
    localparam logic [7:0] CESR_OFS_IRQ_VEC = 8'h04;
    localparam logic [7:0] CESR_OFS_CHA_CNT = 8'h08;
    localparam logic [7:0] CESR_OFS_CHB_CNT = 8'h0c;
    localparam logic [7:0] CESR_OFS_PSR0 = 8'h10;
    localparam logic [7:0] CESR_OFS_CTRL = 8'h14;

    // ====================================================================
    // error flag bit positions
    localparam int CESR_BIT_BUF_UTIL = 0;
    localparam int CESR_BIT_LOCK = 1;
    localparam int CESR_BIT_SYSBUS_FAIL = 2;
    localparam int CESR_BIT_FRAME_IDENT = 3;
    localparam int CESR_BIT_DYN_LEN = 4;
    localparam int CESR_BIT_STATIC_LEN = 5;
    localparam int CESR_BIT_MGMT_LEN = 6;
    localparam int CESR_BIT_MGMT_FRAME = 7;
    localparam int CESR_BIT_ILLEGAL_ADDR = 8;
    localparam int CESR_NUM_FLAGS = 9;

    // vector fields: tx in low byte, rx in high byte
    localparam int CESR_POS_TX_VEC = 0;
    localparam int CESR_POS_RX_VEC = 8;

    // psr0 fields
    localparam int CESR_POS_WAKEUP = 0;
    localparam int CESR_POS_STARTUP = 4;
    localparam int CESR_POS_PROT = 8;
    localparam int CESR_POS_SLOT = 12;
    localparam int CESR_POS_ERROR_MODE_FIELD = 14;

    // control register: bit 0 interface error irq enable, bits 15:8 last utilized buffer
    localparam int CESR_POS_IRQ_EN = 0;
    localparam int CESR_POS_LAST_UTIL = 8;

    // ====================================================================
    // reset values
    localparam logic [15:0] CESR_RST_FLAGS = 16'h0000;
    localparam logic [15:0] CESR_RST_COUNT = 16'h0000;
    localparam logic [7:0] CESR_RST_LAST_UTIL = 8'h00;

    // ====================================================================
    // protocol status encodings
    typedef enum logic [1:0] {
        CESR_ERR_ACTIVE = 2'h0,
        CESR_ERR_PASSIVE = 2'h1,
        CESR_ERR_COMM_HALT = 2'h2
    } cesr_err_mode_t;

    typedef enum logic [1:0] {
        CESR_SLOT_SINGLE = 2'h0,
        CESR_SLOT_ALL_PENDING = 2'h1,
        CESR_SLOT_ALL = 2'h2
    } cesr_slot_mode_t;

    typedef enum logic [2:0] {
        CESR_PS_DEFAULT_CONFIG = 3'h0,
        CESR_PS_CONFIG = 3'h1,
        CESR_PS_WAKEUP = 3'h2,
        CESR_PS_READY = 3'h3,
        CESR_PS_NORMAL_PASSIVE = 3'h4,
        CESR_PS_NORMAL_ACTIVE = 3'h5,
        CESR_PS_HALT = 3'h6,
        CESR_PS_STARTUP = 3'h7
    } cesr_prot_state_t;

    typedef enum logic [3:0] {
        CESR_SU_CS_COLL_RES = 4'h2,
        CESR_SU_CS_LISTEN = 4'h3,
        CESR_SU_INT_CONS_CHECK = 4'h4,
        CESR_SU_INT_LISTEN = 4'h5,
        CESR_SU_INIT_SCHED = 4'h7,
        CESR_SU_CS_CONS_CHECK = 4'ha,
        CESR_SU_CS_JOIN = 4'hf
    } cesr_startup_t;

    typedef enum logic [2:0] {
        CESR_WU_UNDEFINED = 3'h0,
        CESR_WU_RX_HEADER = 3'h1,
        CESR_WU_RX_WUP = 3'h2,
        CESR_WU_COLL_HEADER = 3'h3,
        CESR_WU_COLL_WUP = 3'h4,
        CESR_WU_COLL_UNKNOWN = 3'h5,
        CESR_WU_TRANSMITTED = 3'h6
    } cesr_wakeup_t;

    // ====================================================================
    // carriers
    typedef struct packed {
        cesr_err_mode_t error_mode_field;
        cesr_slot_mode_t slot_mode_field;
        cesr_prot_state_t protocol_state_field;
        cesr_startup_t startup_field;
        cesr_wakeup_t wakeup_field;
    } cesr_proto_status_t;

    // one slot status vector per channel, strobed at slot/segment end
    typedef struct packed {
        logic valid;
        logic syntax_err;
        logic content_err;
        logic boundary_viol;
        logic tx_conflict;
    } cesr_slot_status_t;

    // host write to a buffer control/status register and a lock request
    typedef struct packed {
        logic wr;
        logic [7:0] index;
        logic lock_req;
    } cesr_host_buf_t;

    // error events from buffer and system bus logic, one-cycle pulses
    typedef struct packed {
        logic sysbus_timeout;
        logic frame_ident_mismatch;
        logic dyn_tx_hdr;
        logic [6:0] dyn_tx_len;
        logic static_tx_hdr;
        logic [6:0] static_tx_len;
        logic static_rx_hdr;
        logic [6:0] static_rx_len;
        logic static_rx_frame;
        logic preamble_indicator;
        logic null_frame_indicator;
        logic illegal_addr;
    } cesr_events_t;

    // lengths configured elsewhere
    typedef struct packed {
        logic [6:0] max_dyn_len;
        logic [6:0] static_len;
        logic [3:0] mgmt_vec_len;
    } cesr_len_cfg_t;

endpackage

// [testbench/cesr_engine_model.sv]
`timescale 1ns/10ps
module cesr_engine_model import cesr_pkg::*; (
    input wire logic pclk,
    input wire logic run_a,
    input wire logic run_b,
    input wire logic [3:0] err_bits,
    output cesr_slot_status_t slot_status_a,
    output cesr_slot_status_t slot_status_b
);
    // ====
    // one status vector per cycle while run is held
    // idle error bits are inverted so stale values never pass for fresh ones
    always_ff @(posedge pclk) begin
        slot_status_a <= run_a ? {1'b1, err_bits} : {1'b0, ~err_bits};
        slot_status_b <= run_b ? {1'b1, err_bits} : {1'b0, ~err_bits};
    end
endmodule

// [testbench/cesr_checker.sv]
`timescale 1ns/10ps
module cesr_checker import cesr_pkg::*; #(
    parameter int NUM_BUFS = 64
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire cesr_host_buf_t host_buf,
    input wire logic [NUM_BUFS-1:0] engine_locked,
    input wire cesr_events_t events,
    input wire cesr_slot_status_t slot_status_a,
    input wire cesr_slot_status_t slot_status_b,
    input wire cesr_proto_status_t proto_status,
    input wire logic lock_grant,
    input wire logic mgmt_vec_update
);
    // ====
    // shadow counts; a read shows the count as it stood at the taking edge
    logic [15:0] cnt_a_q;
    logic [15:0] cnt_b_q;
    logic rd_end;
    logic lk;
    assign rd_end = pready && !pwrite;
    assign lk = host_buf.lock_req && (host_buf.index < NUM_BUFS);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_a_q <= 16'h0000;
            cnt_b_q <= 16'h0000;
        end else begin
            cnt_a_q <= cnt_a_q + 16'(slot_status_a.valid && (|slot_status_a[3:0]));
            cnt_b_q <= cnt_b_q + 16'(slot_status_b.valid && (|slot_status_b[3:0]));
        end
    end
    // ====
    // properties
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence taken_s;
        psel && !penable ##1 psel && penable && !pready;
    endsequence
    sequence pp_frame_s;
        events.static_rx_frame && events.preamble_indicator;
    endsequence
    access_answer_a: assert property (taken_s |=> pready) else $error("apb access not answered");
    lock_refuse_a: assert property (lk && engine_locked[host_buf.index] |=> !lock_grant)
        else $error("lock granted on engine locked buffer");
    lock_grant_a: assert property (lk && !engine_locked[host_buf.index] |=> lock_grant)
        else $error("free lock not granted");
    mgmt_hold_a: assert property (pp_frame_s ##0 events.null_frame_indicator |=> !mgmt_vec_update)
        else $error("vector updated from null frame");
    mgmt_update_a: assert property (pp_frame_s ##0 !events.null_frame_indicator |=> mgmt_vec_update)
        else $error("vector not updated");
    count_a_a: assert property (rd_end && paddr == CESR_OFS_CHA_CNT |-> prdata == {16'h0000, $past(cnt_a_q)})
        else $error("channel a count wrong");
    count_b_a: assert property (rd_end && paddr == CESR_OFS_CHB_CNT |-> prdata == {16'h0000, $past(cnt_b_q)})
        else $error("channel b count wrong");
    status_map_a: assert property (rd_end && paddr == CESR_OFS_PSR0 |-> prdata[15:0] ==
        {$past(proto_status[13:10], 2), 1'b0, $past(proto_status[9:3], 2), 1'b0, $past(proto_status[2:0], 2)})
        else $error("protocol status layout wrong");
endmodule

bind cesr_regs cesr_checker #(.NUM_BUFS(NUM_BUFS)) u_cesr_checker (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .prdata(prdata), .pready(pready), .host_buf(host_buf), .engine_locked(engine_locked), .events(events),
    .slot_status_a(slot_status_a), .slot_status_b(slot_status_b), .proto_status(proto_status),
    .lock_grant(lock_grant), .mgmt_vec_update(mgmt_vec_update)
);

// [testbench/tb.sv]
`timescale 1ns/10ps
module tb import cesr_pkg::*; ;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, run_a, run_b;
    logic buf_wr_accept, lock_grant, mgmt_vec_update, iface_err_irq;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] err_bits, mgmt_vec_bytes;
    logic [3:0] su[7];
    logic [13:0] pv;
    logic [63:0] engine_locked, bif, bie, btx;
    cesr_host_buf_t host_buf;
    cesr_events_t events;
    cesr_slot_status_t ssa, ssb;
    cesr_proto_status_t proto_status;
    int bad_count, comparisons;
    // ====
    // length config fixed: dynamic max 20, static 8, vector 4
    cesr_regs dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .host_buf(host_buf), .engine_locked(engine_locked), .events(events), .len_cfg({7'h14, 7'h08, 4'h4}),
        .buffer_irq_flag(bif), .buffer_irq_enable(bie), .buffer_is_tx(btx), .slot_status_a(ssa),
        .slot_status_b(ssb), .proto_status(proto_status), .buf_wr_accept(buf_wr_accept),
        .lock_grant(lock_grant), .mgmt_vec_update(mgmt_vec_update), .mgmt_vec_bytes(mgmt_vec_bytes),
        .iface_err_irq(iface_err_irq));
    cesr_engine_model peer (.pclk(pclk), .run_a(run_a), .run_b(run_b), .err_bits(err_bits),
        .slot_status_a(ssa), .slot_status_b(ssb));
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (int i = 0; i < 20; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        rd = prdata;
        err = pslverr;
        chk("pready", 32'h1, {31'h0, pready});
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk($sformatf("reg %h", a), e, rd);
    endtask
    task automatic ev(input int k, input logic [6:0] n);
        cesr_events_t e;
        e = '0;
        case (k)
            2: e.sysbus_timeout = 1'b1;
            3: e.frame_ident_mismatch = 1'b1;
            4: {e.dyn_tx_hdr, e.dyn_tx_len} = {1'b1, n};
            5: {e.static_tx_hdr, e.static_tx_len} = {1'b1, n};
            6: {e.static_rx_hdr, e.static_rx_len} = {1'b1, n};
            7: {e.static_rx_frame, e.preamble_indicator, e.null_frame_indicator} = {2'h3, n[0]};
            default: e.illegal_addr = 1'b1;
        endcase
        @(posedge pclk);
        events <= e;
        @(posedge pclk);
        events <= '0;
        #1;
    endtask
    task automatic hb(input logic wr, input logic [7:0] idx, input logic lk);
        @(posedge pclk);
        host_buf <= {wr, idx, lk};
        @(posedge pclk);
        host_buf <= '0;
        #1;
    endtask
    task automatic slot(input logic a, input logic b, input logic [3:0] e, input int n);
        @(posedge pclk);
        run_a <= a;
        run_b <= b;
        err_bits <= e;
        repeat (n) @(posedge pclk);
        run_a <= 1'b0;
        run_b <= 1'b0;
        repeat (2) @(posedge pclk);
    endtask
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // ====
    // watchdog: the counter wrap dominates at about 66k cycles
    initial begin
        repeat (90000) @(posedge pclk);
        bad_count++;
        $display("Error watchdog expected 1 seen 0");
        end_sim();
    end
    // ====
    // tests
    initial begin
        {psel, penable, pwrite, run_a, run_b, paddr, pwdata, err_bits} = '0;
        {engine_locked, bif, bie, btx, host_buf, events, proto_status} = '0;
        su = '{4'h2, 4'h3, 4'h4, 4'h5, 4'h7, 4'ha, 4'hf};
        presetn = 1'b0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        rdchk(CESR_OFS_ERR_FLAGS, 32'h0);
        rdchk(CESR_OFS_CTRL, 32'h0);
        apb(1'b0, 8'h40, 32'h0);
        chk("slverr", 32'h1, {31'h0, err});
        $display("test reset done");
        ev(4, 7'h14);
        ev(5, 7'h08);
        ev(6, 7'h04);
        ev(7, 7'h00);
        rdchk(CESR_OFS_ERR_FLAGS, 32'h0);
        apb(1'b1, CESR_OFS_CTRL, 32'h0300);
        hb(1'b1, 8'h03, 1'b0);
        chk("accept", 32'h1, {31'h0, buf_wr_accept});
        hb(1'b1, 8'h04, 1'b0);
        chk("accept", 32'h0, {31'h0, buf_wr_accept});
        engine_locked[5] <= 1'b1;
        hb(1'b0, 8'h05, 1'b1);
        chk("grant", 32'h0, {31'h0, lock_grant});
        hb(1'b0, 8'h06, 1'b1);
        chk("grant", 32'h1, {31'h0, lock_grant});
        rdchk(CESR_OFS_ERR_FLAGS, 32'h3);
        for (int k = 2; k < 9; k++) begin
            ev(k, (k == 4) ? 7'h15 : (k == 5) ? 7'h07 : (k == 6) ? 7'h02 : 7'h01);
            if (k == 6) chk("bytes", 32'h2, {28'h0, mgmt_vec_bytes});
            rdchk(CESR_OFS_ERR_FLAGS, (32'h1 << (k + 1)) - 32'h1);
        end
        chk("irq", 32'h0, {31'h0, iface_err_irq});
        apb(1'b1, CESR_OFS_CTRL, 32'h0301);
        repeat (2) @(posedge pclk);
        #1 chk("irq", 32'h1, {31'h0, iface_err_irq});
        apb(1'b1, CESR_OFS_ERR_FLAGS, 32'h0);
        rdchk(CESR_OFS_ERR_FLAGS, 32'h1ff);
        apb(1'b1, CESR_OFS_ERR_FLAGS, 32'h0f0);
        rdchk(CESR_OFS_ERR_FLAGS, 32'h10f);
        apb(1'b1, CESR_OFS_ERR_FLAGS, 32'h1ff);
        rdchk(CESR_OFS_ERR_FLAGS, 32'h0);
        chk("irq", 32'h0, {31'h0, iface_err_irq});
        $display("test flags done");
        apb(1'b1, CESR_OFS_CHA_CNT, 32'hffff);
        for (int i = 0; i < 4; i++) slot(1'b1, 1'b0, 4'h1 << i, 1);
        slot(1'b1, 1'b1, 4'h0, 3);
        slot(1'b0, 1'b1, 4'h2, 2);
        rdchk(CESR_OFS_CHA_CNT, 32'h4);
        rdchk(CESR_OFS_CHB_CNT, 32'h2);
        slot(1'b1, 1'b0, 4'h8, 65532);
        rdchk(CESR_OFS_CHA_CNT, 32'h0);
        $display("test counters done");
        for (int i = 0; i < 8; i++) begin
            pv = {2'(i % 3), 2'(i % 3), 3'(i), su[i % 7], 3'(i % 7)};
            @(posedge pclk);
            proto_status <= pv;
            rdchk(CESR_OFS_PSR0, {16'h0, pv[13:10], 1'b0, pv[9:3], 1'b0, pv[2:0]});
        end
        @(posedge pclk);
        btx <= 64'h28;
        bif <= 64'h2a8;
        bie <= 64'h2a0;
        rdchk(CESR_OFS_IRQ_VEC, 32'h0705);
        @(posedge pclk);
        bie <= 64'h0;
        rdchk(CESR_OFS_IRQ_VEC, 32'h0);
        $display("test status done");
        end_sim();
    end
endmodule
